//--- common/uart_aux_pkg.sv
package uart_aux_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_CONTROL   = 8'h00; // serial_control_second
  localparam logic [7:0] ADDR_TX_SUM    = 8'h04; // tx_checksum_result
  localparam logic [7:0] ADDR_RX_SUM    = 8'h08; // rx_checksum_result
  localparam logic [7:0] ADDR_ERR_FLAGS = 8'h0c; // serial_error_irq_register
  localparam int         ADDR_W         = 8;     // Decoded address width

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int BIT_CHECKSUM_ENABLE = 0; // Checksum accumulators on
  localparam int BIT_LIN_MODE        = 1; // LIN operating mode
  localparam int BIT_DALI_MODE       = 2; // DALI operating mode
  localparam int BIT_RX_ENABLE       = 3; // receiver_enable_bit
  localparam int BIT_TX_ENABLE       = 4; // transmitter_enable_bit
  localparam int BIT_RUN_ON_OVF      = 5; // run_on_overflow
  localparam int BIT_COLL_IRQ_EN     = 6; // tx_collision_irq_enable
  localparam int BIT_ACT_LINE_TX     = 7; // Activity source: 1 = TX line, 0 = RX line
  localparam int BIT_ACT_RISE_ONLY   = 8; // Activity edge: 1 = rising only
  localparam int CONTROL_W           = 9;
  localparam logic [CONTROL_W-1:0] CONTROL_RESET = 9'h000;

  // ----------------------------------------
  // Error flag register fields (write one to clear)
  // ----------------------------------------
  localparam int BIT_TX_COLLISION = 0; // tx_collision_flag
  localparam int BIT_CHECKSUM_ERR = 1; // checksum_error_flag
  localparam int BIT_RX_FIFO_OVF  = 2; // rx_fifo_overflow_flag
  localparam int FLAGS_W          = 3;
  localparam logic [FLAGS_W-1:0] FLAGS_RESET = 3'h0;

  // ----------------------------------------
  // Checksum values
  // ----------------------------------------
  localparam int         SUM_W      = 8;
  localparam logic [7:0] SUM_RESET  = 8'h00;
  localparam logic [7:0] SUM_GOOD   = 8'hff; // Sum plus inverse checksum byte
  localparam logic [7:0] SUM_ONE    = 8'h01;

  // ----------------------------------------
  // Line monitor
  // ----------------------------------------
  localparam int LINE_RX   = 0;
  localparam int LINE_TX   = 1;
  localparam int LINES     = 2;
  localparam int SYNC_LAST = 2; // Three-stage synchroniser
endpackage

//--- rtl/uart_aux.sv
`timescale 1ns/10ps
// How it works
// - Accumulators run while checksum enable set or in LIN mode
// - Add each transmitted and received byte
// - Fold addition carry back into the sum
// - Checksum error flag only in LIN mode
// - LIN transmit sum includes identifier when enabled
// - LIN receive sum includes identifier when enabled
// - Non-LIN sums cover bytes since last clear
// - Eight-bit sum registers, read/write, reset zero
// - Collision check active when both enables set
// - Mismatched read-back word sets collision flag
// - DALI missing mid-bit transition sets collision flag
// - Run-on-overflow lets receive buffer overflow
// - Line activity edges reset the limit timer
module uart_aux (
  input  wire logic        pclk,              // Peripheral clock
  input  wire logic        presetn,           // Asynchronous reset, active low
  input  wire logic        psel,              // APB select
  input  wire logic        penable,           // APB access phase
  input  wire logic        pwrite,            // APB direction
  input  wire logic [7:0]  paddr,             // APB byte address
  input  wire logic [31:0] pwdata,            // APB write data
  output logic      [31:0] prdata,            // APB read data
  output logic             pready,            // APB ready
  output logic             pslverr,           // APB error on unmapped address
  input  wire logic        tx_byte_done,      // Shifter finished sending a word
  input  wire logic [7:0]  tx_byte,           // Word just sent
  input  wire logic        tx_byte_is_pid,    // Word is the LIN protected identifier
  input  wire logic        rx_byte_done,      // Shifter finished receiving a word
  input  wire logic [7:0]  rx_byte,           // Word just received
  input  wire logic        rx_byte_is_pid,    // Word is the LIN protected identifier
  input  wire logic        rx_byte_is_lin_sum,// Word is the LIN checksum byte
  input  wire logic        dali_midbit_miss,  // Read-back bit lacked mid-bit edge
  input  wire logic        rx_fifo_overflow,  // Receive buffer overflowed
  input  wire logic        rx_pin,            // Receive line, asynchronous
  input  wire logic        tx_pin,            // Transmit line read back, asynchronous
  output logic             collision_irq,     // Collision interrupt request
  output logic             checksum_irq,      // LIN checksum error request
  output logic             overflow_permit,   // Receive buffer may overflow
  output logic             hlt_reset          // One-cycle reset to limit timer
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [uart_aux_pkg::CONTROL_W-1:0] control, next_control;   // Control bits
  logic [uart_aux_pkg::SUM_W-1:0]     tx_sum, next_tx_sum;     // tx_sum_field
  logic [uart_aux_pkg::SUM_W-1:0]     rx_sum, next_rx_sum;     // rx_sum_field
  logic [uart_aux_pkg::FLAGS_W-1:0]   flags, next_flags;       // Error flags
  logic [7:0]                         last_tx, next_last_tx;   // Last word sent
  logic [31:0]                        next_prdata;             // Read data
  logic                               next_pready;             // Ready
  logic                               next_pslverr;            // Error
  logic                               next_coll_irq;           // Collision request
  logic                               next_sum_irq;            // Checksum request
  logic                               next_ovf_permit;         // Overflow permit

  // Decoded control bits
  logic sum_en, lin, dali, both_en;
  assign sum_en  = control[uart_aux_pkg::BIT_CHECKSUM_ENABLE];
  assign lin     = control[uart_aux_pkg::BIT_LIN_MODE];
  assign dali    = control[uart_aux_pkg::BIT_DALI_MODE];
  assign both_en = control[uart_aux_pkg::BIT_RX_ENABLE] & control[uart_aux_pkg::BIT_TX_ENABLE];

  // Bus write strobe: taken at the access edge
  logic wr_en, rd_en, mapped;
  assign wr_en = psel & penable & pready & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign mapped = (paddr == uart_aux_pkg::ADDR_CONTROL) | (paddr == uart_aux_pkg::ADDR_TX_SUM) |
                  (paddr == uart_aux_pkg::ADDR_RX_SUM) | (paddr == uart_aux_pkg::ADDR_ERR_FLAGS);

  // ----------------------------------------
  // Checksum adder with end-around carry
  // ----------------------------------------
  function automatic logic [7:0] fold_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    fold_add = s[7:0] + {7'h00, s[8]}; // Carry wraps into the low bit
  endfunction

  // Byte qualifies for a sum: LIN always sums, identifier only when enabled
  logic tx_take, rx_take;
  assign tx_take = tx_byte_done & (lin ? (sum_en | ~tx_byte_is_pid) : sum_en);
  assign rx_take = rx_byte_done & (lin ? (sum_en | ~rx_byte_is_pid) : sum_en);

  // Receive sum including the current word, for the LIN check
  logic [7:0] rx_sum_new;
  assign rx_sum_new = rx_take ? fold_add(rx_sum, rx_byte) : rx_sum;

  // ----------------------------------------
  // Line activity monitor
  // ----------------------------------------
  logic [uart_aux_pkg::LINES-1:0] line_in;
  logic [uart_aux_pkg::SYNC_LAST:0] sync [uart_aux_pkg::LINES]; // Synchroniser stages
  logic [uart_aux_pkg::LINES-1:0] level, next_level;              // Accepted line level
  logic [uart_aux_pkg::LINES-1:0] rise, fall;                     // Accepted edges
  assign line_in[uart_aux_pkg::LINE_RX] = rx_pin;
  assign line_in[uart_aux_pkg::LINE_TX] = tx_pin;

  genvar g;
  generate
    for (g = 0; g < uart_aux_pkg::LINES; g++) begin : g_line
      // Three flops; stage one feeds only stage two
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync[g] <= '1;
        end else begin
          sync[g] <= {sync[g][1:0], line_in[g]};
        end
      end
      // Change counts once stages two and three agree
      always_comb begin
        rise[g]       = sync[g][1] & sync[g][2] & ~level[g];
        fall[g]       = ~sync[g][1] & ~sync[g][2] & level[g];
        next_level[g] = (rise[g] | fall[g]) ? sync[g][2] : level[g];
      end
    end
  endgenerate

  // Selected line and edge kind
  logic act_sel, act_edge;
  assign act_sel  = control[uart_aux_pkg::BIT_ACT_LINE_TX];
  assign act_edge = rise[act_sel] |
                    (fall[act_sel] & ~control[uart_aux_pkg::BIT_ACT_RISE_ONLY]);

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_control = control;
    next_tx_sum  = tx_sum;
    next_rx_sum  = rx_sum;
    next_flags   = flags;
    next_last_tx = last_tx;
    // Hardware accumulates in the completion cycle
    if (tx_take) begin
      next_tx_sum = fold_add(tx_sum, tx_byte);
    end
    next_rx_sum = rx_sum_new;
    if (tx_byte_done) begin
      next_last_tx = tx_byte;
    end
    // Software writes; a sum write overrides the same-cycle add
    if (wr_en) begin
      case (paddr)
        uart_aux_pkg::ADDR_CONTROL: begin
          next_control = pwdata[uart_aux_pkg::CONTROL_W-1:0];
        end
        uart_aux_pkg::ADDR_TX_SUM: begin
          next_tx_sum = pwdata[uart_aux_pkg::SUM_W-1:0];
        end
        uart_aux_pkg::ADDR_RX_SUM: begin
          next_rx_sum = pwdata[uart_aux_pkg::SUM_W-1:0];
        end
        uart_aux_pkg::ADDR_ERR_FLAGS: begin
          next_flags = flags & ~pwdata[uart_aux_pkg::FLAGS_W-1:0]; // Write one to clear
        end
        default: begin
          next_control = control;
        end
      endcase
    end
    // Flag sets come last so a set wins over a clear
    if (both_en & rx_byte_done & (rx_byte != last_tx)) begin
      next_flags[uart_aux_pkg::BIT_TX_COLLISION] = 1'b1;
    end
    if (both_en & dali & dali_midbit_miss) begin
      next_flags[uart_aux_pkg::BIT_TX_COLLISION] = 1'b1;
    end
    if (lin & rx_byte_is_lin_sum & rx_byte_done & (rx_sum_new != uart_aux_pkg::SUM_GOOD)) begin
      next_flags[uart_aux_pkg::BIT_CHECKSUM_ERR] = 1'b1;
    end
    if (rx_fifo_overflow) begin
      next_flags[uart_aux_pkg::BIT_RX_FIFO_OVF] = 1'b1;
    end
  end

  // Bus answer and outputs, all registered
  always_comb begin
    next_pready     = psel & ~penable;           // Zero-wait answer
    next_pslverr    = psel & ~penable & ~mapped; // Unmapped address
    next_prdata     = 32'h0000_0000;
    if (rd_en) begin
      case (paddr)
        uart_aux_pkg::ADDR_CONTROL:   next_prdata[uart_aux_pkg::CONTROL_W-1:0] = control;
        uart_aux_pkg::ADDR_TX_SUM:    next_prdata[uart_aux_pkg::SUM_W-1:0]     = next_tx_sum;
        uart_aux_pkg::ADDR_RX_SUM:    next_prdata[uart_aux_pkg::SUM_W-1:0]     = next_rx_sum;
        uart_aux_pkg::ADDR_ERR_FLAGS: next_prdata[uart_aux_pkg::FLAGS_W-1:0]   = next_flags;
        default:                      next_prdata = 32'h0000_0000;
      endcase
    end
    next_coll_irq   = next_flags[uart_aux_pkg::BIT_TX_COLLISION] &
                      next_control[uart_aux_pkg::BIT_COLL_IRQ_EN];
    next_sum_irq    = next_flags[uart_aux_pkg::BIT_CHECKSUM_ERR];
    next_ovf_permit = next_control[uart_aux_pkg::BIT_RUN_ON_OVF];
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control         <= uart_aux_pkg::CONTROL_RESET;
      tx_sum          <= uart_aux_pkg::SUM_RESET;
      rx_sum          <= uart_aux_pkg::SUM_RESET;
      flags           <= uart_aux_pkg::FLAGS_RESET;
      last_tx         <= 8'h00;
      level           <= '1;
      prdata          <= 32'h0000_0000;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      collision_irq   <= 1'b0;
      checksum_irq    <= 1'b0;
      overflow_permit <= 1'b0;
      hlt_reset       <= 1'b0;
    end else begin
      control         <= next_control;
      tx_sum          <= next_tx_sum;
      rx_sum          <= next_rx_sum;
      flags           <= next_flags;
      last_tx         <= next_last_tx;
      level           <= next_level;
      prdata          <= next_prdata;
      pready          <= next_pready;
      pslverr         <= next_pslverr;
      collision_irq   <= next_coll_irq;
      checksum_irq    <= next_sum_irq;
      overflow_permit <= next_ovf_permit;
      hlt_reset       <= act_edge;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A word taken with no software write to the same sum
  sequence s_tx_add;
    tx_take && !(wr_en && paddr == uart_aux_pkg::ADDR_TX_SUM);
  endsequence

  a_tx_sum_add: assert property (s_tx_add |=>
      tx_sum == fold_add($past(tx_sum), $past(tx_byte)))
    else $error("transmit sum did not add the word");
  a_tx_sum_hold: assert property ((!tx_take && !wr_en) |=> $stable(tx_sum))
    else $error("transmit sum changed without a word");
  a_rx_pid_skip: assert property ((lin && !sum_en && rx_byte_is_pid && !wr_en) |=>
      $stable(rx_sum))
    else $error("identifier entered receive sum");
  a_carry_fold: assert property ((tx_take && !wr_en &&
      ({1'b0, tx_sum} + {1'b0, tx_byte}) > 9'h0ff) |=>
      tx_sum == ($past(tx_sum) + $past(tx_byte) + 8'h01))
    else $error("carry not folded");
  a_no_checksum_error_flag_nonlin: assert property (!lin |=>
      !$rose(flags[uart_aux_pkg::BIT_CHECKSUM_ERR]))
    else $error("checksum error outside LIN");
  a_collision_set: assert property ((both_en && rx_byte_done &&
      rx_byte != last_tx) |=> flags[uart_aux_pkg::BIT_TX_COLLISION])
    else $error("mismatch did not flag collision");
  a_collision_gate: assert property ((!both_en) |=>
      !$rose(flags[uart_aux_pkg::BIT_TX_COLLISION]))
    else $error("collision flagged while disabled");
  a_dali_midbit: assert property ((both_en && dali && dali_midbit_miss) |=>
      flags[uart_aux_pkg::BIT_TX_COLLISION] &&
      (collision_irq || !control[uart_aux_pkg::BIT_COLL_IRQ_EN]))
    else $error("DALI mid-bit miss not flagged");
  // Each timer reset follows an accepted level change and lasts one cycle
  a_activity_pulse: assert property (hlt_reset |->
      level != $past(level) ##1 !hlt_reset)
    else $error("timer reset without a single line edge");
  a_apb_ready: assert property ((psel && !penable) |=> pready ##1 !pready)
    else $error("APB answer not one cycle");
endmodule

//--- dv/serial_node_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Remote node on the shared line: echo or own words
// ----------------------------------------
module serial_node_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tx_byte_done,       // Word leaving the block
  input  wire logic [7:0] tx_byte,            // Its value
  input  wire logic       echo_en,            // Line looped back to receiver
  input  wire logic [7:0] flip_mask,          // Bits disturbed on the wire
  input  wire logic       inj,                // Node sends its own word
  input  wire logic [7:0] inj_byte,
  input  wire logic       inj_pid,
  input  wire logic       inj_sum,
  output logic            rx_byte_done,
  output logic [7:0]      rx_byte,
  output logic            rx_byte_is_pid,
  output logic            rx_byte_is_lin_sum,
  output logic            rx_pin
);
  logic [2:0] low_cnt; // Start-bit cycles left on the line
  // Word delivery; data does not hold between words
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_byte_done <= 1'b0;
      rx_byte <= 8'h00;
      rx_byte_is_pid <= 1'b0;
      rx_byte_is_lin_sum <= 1'b0;
      low_cnt <= 3'h0;
      rx_pin <= 1'b1;
    end else begin
      rx_byte_done <= inj | (echo_en & tx_byte_done);
      if (inj) begin
        rx_byte <= inj_byte;
        rx_byte_is_pid <= inj_pid;
        rx_byte_is_lin_sum <= inj_sum;
      end else if (echo_en & tx_byte_done) begin
        rx_byte <= tx_byte ^ flip_mask; // Disturbed read-back
        rx_byte_is_pid <= 1'b0;
        rx_byte_is_lin_sum <= 1'b0;
      end else begin
        rx_byte <= ~rx_byte; // Stale data keeps moving
      end
      if (rx_byte_done) begin
        low_cnt <= 3'h4;
      end else if (low_cnt != 3'h0) begin
        low_cnt <= low_cnt - 3'h1;
      end
      rx_pin <= (low_cnt == 3'h0) && !rx_byte_done; // Idle high
    end
  end
endmodule

//--- dv/tb_uart_aux.sv
`timescale 1ns/10ps
module tb_uart_aux;
  // ----------------------------------------
  // Signals and constants
  // ----------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr, tx_byte, rx_byte, inj_byte, flip_mask, seed, b, s;
  logic [31:0] pwdata, prdata, q;
  logic        tx_byte_done, tx_byte_is_pid, rx_byte_done, rx_byte_is_pid;
  logic        rx_byte_is_lin_sum, dali_midbit_miss, rx_fifo_overflow;
  logic        rx_pin, tx_pin, collision_irq, checksum_irq, overflow_permit;
  logic        hlt_reset, echo_en, inj, inj_pid, inj_sum;
  int          fails, checks_done, cyc, hl_cnt, n0;
  localparam logic [7:0]  A_C = uart_aux_pkg::ADDR_CONTROL;
  localparam logic [7:0]  A_T = uart_aux_pkg::ADDR_TX_SUM;
  localparam logic [7:0]  A_R = uart_aux_pkg::ADDR_RX_SUM;
  localparam logic [7:0]  A_F = uart_aux_pkg::ADDR_ERR_FLAGS;
  localparam logic [31:0] CE = 32'h1 << uart_aux_pkg::BIT_CHECKSUM_ENABLE;
  localparam logic [31:0] LIN = 32'h1 << uart_aux_pkg::BIT_LIN_MODE;
  localparam logic [31:0] DALI = 32'h1 << uart_aux_pkg::BIT_DALI_MODE;
  localparam logic [31:0] RXE = 32'h1 << uart_aux_pkg::BIT_RX_ENABLE;
  localparam logic [31:0] TXE = 32'h1 << uart_aux_pkg::BIT_TX_ENABLE;
  localparam logic [31:0] ROV = 32'h1 << uart_aux_pkg::BIT_RUN_ON_OVF;
  localparam logic [31:0] CIE = 32'h1 << uart_aux_pkg::BIT_COLL_IRQ_EN;
  localparam logic [31:0] ATX = 32'h1 << uart_aux_pkg::BIT_ACT_LINE_TX;
  localparam logic [31:0] RISE = 32'h1 << uart_aux_pkg::BIT_ACT_RISE_ONLY;
  localparam logic [31:0] MODES [3] = '{32'h0, LIN, DALI};
  localparam logic [31:0] HL_CV [3] = '{32'h0, RISE, ATX};
  localparam int          HL_EXP [3] = '{2, 1, 2};

  uart_aux u_uart_aux (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .tx_byte_done, .tx_byte, .tx_byte_is_pid,
    .rx_byte_done, .rx_byte, .rx_byte_is_pid, .rx_byte_is_lin_sum, .dali_midbit_miss,
    .rx_fifo_overflow, .rx_pin, .tx_pin, .collision_irq, .checksum_irq,
    .overflow_permit, .hlt_reset);
  serial_node_model u_serial_node_model (.pclk, .presetn, .tx_byte_done, .tx_byte,
    .echo_en, .flip_mask, .inj, .inj_byte, .inj_pid, .inj_sum, .rx_byte_done,
    .rx_byte, .rx_byte_is_pid, .rx_byte_is_lin_sum, .rx_pin);

  // ----------------------------------------
  // Clock, watchdog, timer-reset pulse count
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    hl_cnt += int'(hlt_reset === 1'b1);
    if (cyc > 20000) begin
      fails++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] fold(input logic [7:0] a, input logic [7:0] c);
    logic [8:0] t;
    t = {1'b0, a} + {1'b0, c};
    return t[7:0] + {7'h00, t[8]}; // Carry wraps back in
  endfunction
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] x);
    checks_done++;
    if (seen !== x) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, x, seen);
    end
  endtask
  // One APB transfer; waits for pready, the watchdog bounds the wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, q, x);
  endtask
  // Core reports a sent word; the line dips two cycles to pass the filter
  task automatic tx_word(input logic [7:0] v, input logic p);
    @(posedge pclk);
    tx_byte_done <= 1'b1;
    tx_byte <= v;
    tx_byte_is_pid <= p;
    tx_pin <= 1'b0;
    @(posedge pclk);
    tx_byte_done <= 1'b0;
    tx_byte <= ~v;
    @(posedge pclk);
    tx_pin <= 1'b1;
  endtask
  // Remote node sends its own word
  task automatic rx_word(input logic [7:0] v, input logic p, input logic m);
    @(posedge pclk);
    inj <= 1'b1;
    inj_byte <= v;
    inj_pid <= p;
    inj_sum <= m;
    @(posedge pclk);
    inj <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, tx_byte_done, tx_byte, tx_byte_is_pid} = '0;
    {dali_midbit_miss, rx_fifo_overflow, echo_en, flip_mask, inj, inj_byte} = '0;
    {inj_pid, inj_sum, fails, checks_done, cyc, hl_cnt} = '0;
    tx_pin = 1'b1;
    presetn = 1'b0;
    seed = 8'h46;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (MODES[i]) rd(A_C + 8'(4 * i), 32'h0, "reset value");
    rd(A_F, 32'h0, "flags reset");
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped error", {31'h0, e}, 32'h1);
    wr(A_R, 32'h1ff);
    rd(A_R, 32'hff, "rx sum write");
    $display("test registers done");
    wr(A_C, RXE | TXE);
    echo_en <= 1'b1;
    wr(A_R, 32'h0);
    tx_word(8'h5a, 1'b0);
    rd(A_T, 32'h0, "tx sum disabled");
    rd(A_R, 32'h0, "rx sum disabled");
    wr(A_C, CE | RXE | TXE);
    b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      s = (i < 2) ? 8'hff : seed;
      tx_word(s, 1'b0);
      b = fold(b, s);
      rd(A_T, {24'h0, b}, "tx running sum");
    end
    tx_word(~b, 1'b0);
    apb(1'b0, A_R, 32'h0);
    chk("rx sum plus one", {24'h0, q[7:0] + 8'h01}, 32'h0);
    wr(A_C, CE | TXE); // Receiver off: the lone word must not collide
    rx_word(8'h00, 1'b0, 1'b1);
    rd(A_F, 32'h0, "no checksum error");
    chk("checksum irq", {31'h0, checksum_irq}, 32'h0);
    $display("test checksum done");
    foreach (MODES[i]) begin
      wr(A_C, RXE | TXE | CIE | MODES[i]);
      flip_mask <= 8'h00;
      tx_word(8'h33, 1'b0);
      rd(A_F, 32'h0, "clean read-back");
      flip_mask <= 8'h20;
      tx_word(8'h33, 1'b0);
      rd(A_F, 32'h1, "collision flag");
      chk("collision irq", {31'h0, collision_irq}, 32'h1);
      wr(A_F, 32'h1);
    end
    rd(A_F, 32'h0, "collision cleared");
    wr(A_C, RXE | TXE);
    tx_word(8'h33, 1'b0);
    rd(A_F, 32'h1, "masked collision flag");
    chk("irq masked", {31'h0, collision_irq}, 32'h0);
    wr(A_F, 32'h1);
    wr(A_C, TXE);
    tx_word(8'h33, 1'b0);
    rd(A_F, 32'h0, "receiver off");
    wr(A_C, RXE | TXE | DALI);
    @(posedge pclk) dali_midbit_miss <= 1'b1;
    @(posedge pclk) dali_midbit_miss <= 1'b0;
    rd(A_F, 32'h1, "mid-bit miss");
    wr(A_F, 32'h1);
    $display("test collision done");
    echo_en <= 1'b0;
    for (int c = 0; c < 2; c++) begin
      wr(A_C, LIN | (c == 1 ? CE : 32'h0));
      wr(A_T, 32'h0);
      wr(A_R, 32'h0);
      tx_word(8'h3c, 1'b1);
      tx_word(8'h81, 1'b0);
      rd(A_T, {24'h0, c == 1 ? fold(8'h3c, 8'h81) : 8'h81}, "lin tx sum");
      rx_word(8'h3c, 1'b1, 1'b0);
      rx_word(8'hc5, 1'b0, 1'b0);
      rd(A_R, {24'h0, c == 1 ? fold(8'h3c, 8'hc5) : 8'hc5}, "lin rx sum");
    end
    rx_word(~fold(8'h3c, 8'hc5), 1'b0, 1'b1);
    rd(A_F, 32'h0, "lin sum good");
    rx_word(8'h5a, 1'b0, 1'b1); // Sum is 0xff: any byte but 0x00 or 0xff breaks it
    rd(A_F, 32'h2, "lin sum bad");
    chk("lin error irq", {31'h0, checksum_irq}, 32'h1);
    wr(A_F, 32'h2);
    $display("test lin done");
    wr(A_C, ROV);
    repeat (2) @(posedge pclk);
    chk("overflow permit", {31'h0, overflow_permit}, 32'h1);
    @(posedge pclk) rx_fifo_overflow <= 1'b1;
    @(posedge pclk) rx_fifo_overflow <= 1'b0;
    rd(A_F, 32'h4, "overflow flag");
    wr(A_F, 32'h4);
    rd(A_F, 32'h0, "overflow cleared");
    foreach (HL_CV[i]) begin
      wr(A_C, HL_CV[i]);
      repeat (8) @(posedge pclk);
      n0 = hl_cnt;
      rx_word(8'h55, 1'b0, 1'b0);
      tx_word(8'h55, 1'b0);
      repeat (12) @(posedge pclk);
      chk("timer resets", 32'(hl_cnt - n0), 32'(HL_EXP[i]));
    end
    $display("test activity done");
    stop_test();
  end
endmodule
